// ==== hdl/ccl_comparator_ctl.sv ====
// Purpose: Control and status logic around an analog voltage comparator
// Assumes: Registers reached over the 8-bit special-function register port
// Notes:   The raw pin output is combinational so it survives a halted clock
// Overview of operation
// (R01) The result can be read by software, raise edge flags and drive pins, in any mix.
// (R02) Pin output comes in a clock-synchronised form and a raw asynchronous form.
// (R03) The raw output stays valid with the clock halted, passing through no clocked stage.
// (R04) While disabled, both pin outputs read logic low.
// (R05) A two-bit response mode field sets comparator speed against power.
// (R06) Rising and falling transitions are detected as separate events.
// (R07) A falling transition sets the fall flag in control bit 4.
// (R08) A rising transition sets the rise flag in control bit 5.
// (R09) The edge flags stay set until software writes them to zero.
// (R10) Read-only control bit 6 returns the current comparator result.
// (R11) Control bit 7 enables the comparator when 1 and disables it when 0.
// (R12) Control bits 1 to 0 select negative hysteresis of none, 5, 10 or 20 mV.
// (R13) Control bits 3 to 2 select positive hysteresis the same way.
// (R14) The input select register holds separate two-bit positive and negative pin fields.
// (R15) The result passes a two-stage synchroniser before any edge comparison.
// (R16) Negative codes pick pins 1, 3, 5, 7; positive codes pick pins 0, 2, 4, 6.
// (R17) Hysteresis codes go to the analog comparator unchanged, 00 meaning none.
`timescale 1ns/10ps
module ccl_comparator_ctl (
	input  wire logic                     mclk_i,
	input  wire logic                     sys_rst_i,
	input  wire ccl_pkg::ccl_sfr_req_type sfr_req_i,
	output logic [7:0]                    sfr_rdata_o,
	input  wire logic                     cmp_raw_i,
	output ccl_pkg::ccl_analog_ctl_type   analog_ctl_o,
	output logic                          latched_cmp_pin_out_o,
	output logic                          raw_cmp_pin_out_o
);
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] input_sel;
		logic [1:0] mode;
		logic [7:0] rdata;
		logic       pin_out;
		ccl_pkg::ccl_analog_ctl_type ana;
	} ccl_state_type;

	ccl_state_type state_ff;
	ccl_state_type nxt_state;

	logic cmp_gated;
	logic sync_level;
	logic sync_rise;
	logic sync_fall;

	// One-hot analog switch for a two-bit pin select code
	function automatic logic [7:0] ccl_pin_decode(input logic [1:0] code,
	                                              input logic [2:0] base);
		logic [2:0] pin;
		pin            = {code, 1'b0} | base;
		ccl_pin_decode = 8'h01 << pin;
	endfunction : ccl_pin_decode

	// Disabled comparator reads low; the enable flop holds its value when halted
	assign cmp_gated = cmp_raw_i & state_ff.control[ccl_pkg::CCL_CTL_EN]; // [R04] [R11]

	ccl_sync_edge #(
		.STAGES (ccl_pkg::CCL_SYNC_STAGES)
	) u_sync (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (cmp_gated), // [R15]
		.level_o   (sync_level),
		.rise_o    (sync_rise),
		.fall_o    (sync_fall)
	);

	always_comb begin
		logic wr_ctl;
		logic wr_mx;
		logic wr_md;
		logic en;
		wr_ctl    = 1'b0;
		wr_mx     = 1'b0;
		wr_md     = 1'b0;
		en        = 1'b0;
		nxt_state = state_ff;
		wr_ctl    = sfr_req_i.wr && (sfr_req_i.addr == ccl_pkg::CCL_ADDR_CONTROL);
		wr_mx     = sfr_req_i.wr && (sfr_req_i.addr == ccl_pkg::CCL_ADDR_INPUT_SEL);
		wr_md     = sfr_req_i.wr && (sfr_req_i.addr == ccl_pkg::CCL_ADDR_MODE);
		en        = state_ff.control[ccl_pkg::CCL_CTL_EN];

		if (wr_ctl) begin
			// Bit 6 is status, never stored from the bus
			nxt_state.control[ccl_pkg::CCL_CTL_EN] =
				sfr_req_i.wdata[ccl_pkg::CCL_CTL_EN]; // [R11]
			nxt_state.control[ccl_pkg::CCL_CTL_RISE] =
				sfr_req_i.wdata[ccl_pkg::CCL_CTL_RISE]; // [R09]
			nxt_state.control[ccl_pkg::CCL_CTL_FALL] =
				sfr_req_i.wdata[ccl_pkg::CCL_CTL_FALL]; // [R09]
			nxt_state.control[ccl_pkg::CCL_CTL_PHY_H:ccl_pkg::CCL_CTL_NHY_L] =
				sfr_req_i.wdata[ccl_pkg::CCL_CTL_PHY_H:ccl_pkg::CCL_CTL_NHY_L]; // [R12] [R13]
		end
		if (wr_mx) begin
			nxt_state.input_sel = 8'h00;
			nxt_state.input_sel[ccl_pkg::CCL_MX_NEG_H:ccl_pkg::CCL_MX_NEG_L] =
				sfr_req_i.wdata[ccl_pkg::CCL_MX_NEG_H:ccl_pkg::CCL_MX_NEG_L]; // [R14]
			nxt_state.input_sel[ccl_pkg::CCL_MX_POS_H:ccl_pkg::CCL_MX_POS_L] =
				sfr_req_i.wdata[ccl_pkg::CCL_MX_POS_H:ccl_pkg::CCL_MX_POS_L]; // [R14]
		end
		if (wr_md) begin
			nxt_state.mode = sfr_req_i.wdata[ccl_pkg::CCL_MD_H:ccl_pkg::CCL_MD_L]; // [R05]
		end

		// Hardware set wins over a software clear in the same cycle
		if (sync_rise && en) begin
			nxt_state.control[ccl_pkg::CCL_CTL_RISE] = 1'b1; // [R06] [R08]
		end
		if (sync_fall && en) begin
			nxt_state.control[ccl_pkg::CCL_CTL_FALL] = 1'b1; // [R06] [R07]
		end
		// Gated like the pin so a disabled comparator never reads high
		nxt_state.control[ccl_pkg::CCL_CTL_OUT] =
			sync_level & nxt_state.control[ccl_pkg::CCL_CTL_EN]; // [R10] [R04]

		nxt_state.pin_out = sync_level & nxt_state.control[ccl_pkg::CCL_CTL_EN]; // [R02] [R04]

		nxt_state.ana.enable            = nxt_state.control[ccl_pkg::CCL_CTL_EN];
		nxt_state.ana.pos_hyst_sel      =
			nxt_state.control[ccl_pkg::CCL_CTL_PHY_H:ccl_pkg::CCL_CTL_PHY_L]; // [R13] [R17]
		nxt_state.ana.neg_hyst_sel      =
			nxt_state.control[ccl_pkg::CCL_CTL_NHY_H:ccl_pkg::CCL_CTL_NHY_L]; // [R12] [R17]
		nxt_state.ana.response_mode_sel = nxt_state.mode; // [R05]
		nxt_state.ana.pin_switch        =
			ccl_pin_decode(nxt_state.input_sel[ccl_pkg::CCL_MX_POS_H:ccl_pkg::CCL_MX_POS_L],
			               ccl_pkg::CCL_POS_PIN_BASE) |
			ccl_pin_decode(nxt_state.input_sel[ccl_pkg::CCL_MX_NEG_H:ccl_pkg::CCL_MX_NEG_L],
			               ccl_pkg::CCL_NEG_PIN_BASE); // [R16]

		// Read data returns the registers as they stand at the read edge
		case (sfr_req_i.addr)
			ccl_pkg::CCL_ADDR_CONTROL: begin
				nxt_state.rdata = state_ff.control; // [R01] [R10]
			end
			ccl_pkg::CCL_ADDR_INPUT_SEL: begin
				nxt_state.rdata = state_ff.input_sel;
			end
			ccl_pkg::CCL_ADDR_MODE: begin
				nxt_state.rdata = {6'h00, state_ff.mode};
			end
			default: begin
				nxt_state.rdata = 8'h00;
			end
		endcase
		if (!sfr_req_i.rd) begin
			nxt_state.rdata = state_ff.rdata;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_ff           <= '0;
			state_ff.control   <= ccl_pkg::CCL_RST_CONTROL;
			state_ff.input_sel <= ccl_pkg::CCL_RST_INPUT_SEL;
			state_ff.mode      <= ccl_pkg::CCL_RST_MODE;
			state_ff.ana.response_mode_sel <= ccl_pkg::CCL_RST_MODE;
			state_ff.ana.pin_switch <= 8'h03;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign sfr_rdata_o           = state_ff.rdata;
	assign analog_ctl_o          = state_ff.ana;
	assign latched_cmp_pin_out_o = state_ff.pin_out; // [R02]
	// Deliberately unclocked path so the pin follows the comparator in stop mode
	assign raw_cmp_pin_out_o     = cmp_gated; // [R02] [R03] [R04]
endmodule : ccl_comparator_ctl

// ==== hdl/ccl_pkg.sv ====
// Purpose: Shared constants and carrier types for the comparator control logic
// Assumes: 8-bit special-function register port, single system clock
// Notes:   Offsets are the byte addresses of the register port
package ccl_pkg;
	localparam logic [7:0] CCL_ADDR_INPUT_SEL = 8'h9f;
	localparam logic [7:0] CCL_ADDR_CONTROL   = 8'hf8;
	localparam logic [7:0] CCL_ADDR_MODE      = 8'h9d;

	localparam logic [7:0] CCL_RST_INPUT_SEL  = 8'h00;
	localparam logic [7:0] CCL_RST_CONTROL    = 8'h00;
	localparam logic [1:0] CCL_RST_MODE       = 2'h2;

	// Control register field positions
	localparam int CCL_CTL_EN    = 7;
	localparam int CCL_CTL_OUT   = 6;
	localparam int CCL_CTL_RISE  = 5;
	localparam int CCL_CTL_FALL  = 4;
	localparam int CCL_CTL_PHY_H = 3;
	localparam int CCL_CTL_PHY_L = 2;
	localparam int CCL_CTL_NHY_H = 1;
	localparam int CCL_CTL_NHY_L = 0;
	// Input select register field positions
	localparam int CCL_MX_NEG_H  = 5;
	localparam int CCL_MX_NEG_L  = 4;
	localparam int CCL_MX_POS_H  = 1;
	localparam int CCL_MX_POS_L  = 0;
	// Mode register field positions
	localparam int CCL_MD_H      = 1;
	localparam int CCL_MD_L      = 0;

	// Pin offset of the select codes: positive even pins, negative odd pins
	localparam logic [2:0] CCL_POS_PIN_BASE = 3'h0;
	localparam logic [2:0] CCL_NEG_PIN_BASE = 3'h1;

	localparam int CCL_SYNC_STAGES = 2;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} ccl_sfr_req_type;

	typedef struct packed {
		logic       enable;
		logic [1:0] pos_hyst_sel;
		logic [1:0] neg_hyst_sel;
		logic [1:0] response_mode_sel;
		logic [7:0] pin_switch;
	} ccl_analog_ctl_type;
endpackage : ccl_pkg

// ==== hdl/ccl_sync_edge.sv ====
// Purpose: Two-stage synchroniser with rising and falling edge detection
// Assumes: Input is asynchronous to mclk_i
// Notes:   Edge pulses last one clock; level output is registered
`timescale 1ns/10ps
module ccl_sync_edge #(
	parameter int STAGES = ccl_pkg::CCL_SYNC_STAGES
) (
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	input  wire logic async_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	// Fewer than two stages would let a metastable first flop reach the edge logic
	if (STAGES < 2) begin : g_bad_stages
		$error("ccl_sync_edge needs at least two stages");
	end

	typedef struct packed {
		logic [STAGES-1:0] chain;
		logic              prev;
		logic              rise;
		logic              fall;
	} ccl_se_state_type;

	ccl_se_state_type state_ff;
	ccl_se_state_type nxt_state;

	always_comb begin
		nxt_state       = state_ff;
		nxt_state.chain = {state_ff.chain[STAGES-2:0], async_i};
		// Only the last stage is compared; the first is metastability-prone
		nxt_state.prev  = state_ff.chain[STAGES-1];
		nxt_state.rise  = state_ff.chain[STAGES-1] & ~state_ff.prev;
		nxt_state.fall  = ~state_ff.chain[STAGES-1] & state_ff.prev;
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign level_o = state_ff.prev;
	assign rise_o  = state_ff.rise;
	assign fall_o  = state_ff.fall;
endmodule : ccl_sync_edge

// ==== tb/ccl_analog_model.sv ====
// Purpose: Far-side pins, each high or low, and the comparator
// Assumes: Even and odd switch bits are one-hot
// Notes:   Hysteresis and response delay are not modelled
`timescale 1ns/10ps
module ccl_analog_model (
	input  wire ccl_pkg::ccl_analog_ctl_type ctl_i,
	input  wire logic [7:0]                  hi_pins_i,
	output logic                             cmp_o
);
	assign cmp_o = |(ctl_i.pin_switch & hi_pins_i & 8'h55)
		& ~|(ctl_i.pin_switch & hi_pins_i & 8'haa);
endmodule : ccl_analog_model

// ==== tb/ccl_ctl_props.sv ====
// Purpose: Port assertions for the comparator control logic
// Assumes: Sees only the top module ports
// Notes:   The rise latency bound keeps one spare cycle, the off bound four
`timescale 1ns/10ps
module ccl_ctl_props (
	input wire logic                        mclk_i,
	input wire logic                        sys_rst_i,
	input wire ccl_pkg::ccl_sfr_req_type    sfr_req_i,
	input wire logic [7:0]                  sfr_rdata_o,
	input wire logic                        cmp_raw_i,
	input wire ccl_pkg::ccl_analog_ctl_type analog_ctl_o,
	input wire logic                        latched_cmp_pin_out_o,
	input wire logic                        raw_cmp_pin_out_o
);
	logic       en, w, r;
	logic [7:0] a, sw;
	logic [4:0] cf;
	logic [1:0] md;
	assign en = analog_ctl_o.enable;
	assign w  = sfr_req_i.wr;
	assign r  = sfr_req_i.rd;
	assign a  = sfr_req_i.addr;
	assign sw = (8'h01 << {sfr_req_i.wdata[1:0], 1'b0}) | (8'h02 << {sfr_req_i.wdata[5:4], 1'b0});
	assign cf = {sfr_req_i.wdata[7], sfr_req_i.wdata[3:0]};
	assign md = sfr_req_i.wdata[1:0];
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	raw_off_a: assert property (!en |-> !raw_cmp_pin_out_o)
		else $error("raw pin high while off");
	raw_follow_a: assert property (en |-> raw_cmp_pin_out_o == cmp_raw_i)
		else $error("raw pin not following");
	latch_off_a: assert property (!en [*5] |-> !latched_cmp_pin_out_o)
		else $error("latched pin high while off");
	latch_rise_a: assert property ($rose(cmp_raw_i) ##0 (en && cmp_raw_i) [*6]
		|-> latched_cmp_pin_out_o) else $error("latched pin late");
	ctl_write_a: assert property (w && a == 8'hf8
		|=> {en, analog_ctl_o.pos_hyst_sel, analog_ctl_o.neg_hyst_sel} == $past(cf))
		else $error("control fields wrong");
	mux_write_a: assert property (w && a == 8'h9f |=> analog_ctl_o.pin_switch == $past(sw))
		else $error("pin switch wrong");
	mode_write_a: assert property (w && a == 8'h9d
		|=> analog_ctl_o.response_mode_sel == $past(md)) else $error("mode wrong");
	rd_hold_a: assert property (!r |=> $stable(sfr_rdata_o))
		else $error("read data moved");
	unmapped_rd_a: assert property (r && !(a inside {8'h9f, 8'hf8, 8'h9d})
		|=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
	out_read_a: assert property (r && a == 8'hf8
		|=> sfr_rdata_o[6] == $past(latched_cmp_pin_out_o)) else $error("state bit wrong");
	cover property (w && a == 8'hf8 && cf[4]);
	cover property ($rose(latched_cmp_pin_out_o));
	cover property ($fell(latched_cmp_pin_out_o) && en);
endmodule : ccl_ctl_props
bind ccl_comparator_ctl ccl_ctl_props u_ccl_ctl_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
	.sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .cmp_raw_i(cmp_raw_i),
	.analog_ctl_o(analog_ctl_o), .latched_cmp_pin_out_o(latched_cmp_pin_out_o),
	.raw_cmp_pin_out_o(raw_cmp_pin_out_o));

// ==== tb/test_comparator_control_logic.sv ====
// Purpose: Self-checking bench for the comparator control logic
// Assumes: Register model mirrors the writable bits
// Notes:   Pins go low before enabling, so no sub-cycle pulse
`timescale 1ns/10ps
module test_comparator_control_logic;
	logic                        mclk_i = 0, sys_rst_i = 1, cmp, lat, raw, om = 0;
	logic [7:0]                  rdata, pm, hi_pins = 8'h00;
	logic [7:0]                  rm [256] = '{default: 8'h00};
	logic [7:0]                  ad [4] = '{8'h9f, 8'hf8, 8'h9d, 8'h55};
	ccl_pkg::ccl_sfr_req_type    req = '0;
	ccl_pkg::ccl_analog_ctl_type actl;
	int                          fail_count = 0, num_checks = 0, seed = 28509;
	ccl_comparator_ctl u_ccl_comparator_ctl (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.sfr_req_i(req), .sfr_rdata_o(rdata), .cmp_raw_i(cmp), .analog_ctl_o(actl),
		.latched_cmp_pin_out_o(lat), .raw_cmp_pin_out_o(raw));
	ccl_analog_model u_ccl_analog_model (.ctl_i(actl), .hi_pins_i(hi_pins), .cmp_o(cmp));
	initial forever #50 mclk_i = ~mclk_i;
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge mclk_i) req <= '{a, 1'b1, 1'b0, d};
		@(posedge mclk_i) req <= '0;
		#1;
		case (a)
			8'hf8: rm[a] = d & 8'hbf;
			8'h9f: rm[a] = d & 8'h33;
			8'h9d: rm[a] = d & 8'h03;
			default: ;
		endcase
	endtask : wr
	task automatic rd(logic [7:0] a);
		logic [7:0] e;
		e = (a == 8'hf8) ? {rm[a][7], om, rm[a][5:0]} : rm[a];
		@(posedge mclk_i) req <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge mclk_i) req <= '0;
		#1 chk("read", rdata, e);
	endtask : rd
	// Flags only move while enabled; disabling high gives no fall flag
	task automatic setp(logic [7:0] p);
		logic o;
		o = rm[8'hf8][7] & p[2 * rm[8'h9f][1:0]] & ~p[2 * rm[8'h9f][5:4] + 1];
		if (rm[8'hf8][7] && o != om) rm[8'hf8][o ? 5 : 4] = 1'b1;
		om = o;
		@(posedge mclk_i) hi_pins <= p;
		repeat (8) @(posedge mclk_i);
		#1 chk("raw", raw, o);
		chk("latch", lat, o);
	endtask : setp
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge mclk_i);
		fail_count++;
		report_and_stop;
	end
	initial begin
		rm[8'h9d] = 8'h02;
		repeat (3) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		#1 chk("rst pins", actl.pin_switch, 8'h03);
		foreach (ad[i]) rd(ad[i]);
		$display("done reset and map");
		for (int i = 0; i < 4; i++) begin
			wr(8'h9d, {6'h3f, i[1:0]});
			chk("mode", actl.response_mode_sel, i[1:0]);
			rd(8'h9d);
			wr(8'hf8, {4'hc, i[1:0], ~i[1:0]});
			chk("hyst", {actl.pos_hyst_sel, actl.neg_hyst_sel}, {i[1:0], ~i[1:0]});
			chk("enable", actl.enable, 8'h01);
			rd(8'hf8);
			wr(8'h9f, 8'($random(seed)));
			pm = 8'h01 << 2 * rm[8'h9f][1:0];
			chk("pins", actl.pin_switch, pm | 8'h02 << 2 * rm[8'h9f][5:4]);
			rd(8'h9f);
		end
		$display("done fields");
		setp(pm);
		rd(8'hf8);
		setp(8'h00);
		rd(8'hf8);
		setp(pm);
		rd(8'hf8);
		wr(8'hf8, 8'h8c);
		rd(8'hf8);
		wr(8'hf8, 8'h0c);
		setp(pm);
		rd(8'hf8);
		setp(8'h00);
		wr(8'hf8, 8'h80);
		repeat (6) setp(8'($random(seed)));
		rd(8'hf8);
		$display("done edges");
		report_and_stop;
	end
endmodule : test_comparator_control_logic
